// ==== hdl/vrc_cfg_bank.sv ====
// configuration and status command bank of a multiphase regulator controller
// What this block does
// - trim is signed VID steps onto setpoint
// - trim applies only under management-bus control
// - phase minimum above configured count: discard, flag
// - state-zero minimum unless link commands other
// - bits 2:0 state-zero minimum, 001..110
// - bits 5:3 state-one minimum, link only
// - bits 12:10 state-two minimum, link only
// - link mirrors writable only when lock released
// - link mirrors volatile, never saved or restored
// - VID mirror reports last commanded 10-bit code
// - power state mirror reports last link command
// - mirrors map link registers 12h, 15h, 33h
// - energy command starts per-interval power accumulation
// - accumulate until 20-bit interval count reached
// - max-current mirror only reports, no protection
// - max-temperature mirror only reports, no protection
// - slew mirrors report only, real rates elsewhere
`timescale 1ns/1ps
`include "vrc_cfg_regs.svh"
module vrc_cfg_bank #(
    parameter int INTERVAL_CYCLES = `VRC_INTERVAL_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input vrc_cfg_pkg::vrc_cmd_t cmd,
    output vrc_cfg_pkg::vrc_rsp_t rsp,
    output logic cml_unsupported_data_set,
    input wire logic [`VRC_PH_W-1:0] configured_phases,
    input wire logic link_control,
    input wire logic link_register_lock_released,
    input wire logic [`VRC_VID_W-1:0] vout_command_vid,
    input vrc_cfg_pkg::vrc_link_upd_t link_upd,
    output vrc_cfg_pkg::vrc_link_view_t link_view,
    output logic [`VRC_VID_W-1:0] setpoint_vid,
    output logic [`VRC_PH_W-1:0] min_phases_active,
    output logic [`VRC_FRACT_W-1:0] skip_offset_fraction,
    input wire logic [`VRC_POWER_W-1:0] interval_avg_power,
    output logic [`VRC_ENERGY_W-1:0] energy_total,
    output logic energy_running,
    output logic energy_done
);
    localparam int TICK_W = $clog2(INTERVAL_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_PERIOD = TICK_W'(INTERVAL_CYCLES);
    localparam logic [`VRC_THREAD_W:0] THREAD_FULL = 21'h100000;

    vrc_cfg_pkg::vrc_state_t st_reg;
    vrc_cfg_pkg::vrc_state_t st_next;
    logic interval_tick;
    logic restart;

    // ============================================================
    // interval divider
    // a rewrite mid-run clears the divider, else the first new interval runs short
    vrc_interval_tick #(
        .CNT_W(TICK_W),
        .PERIOD(TICK_PERIOD)
    ) u_tick (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(st_reg.en_state == vrc_cfg_pkg::VRC_EN_RUN && !restart),
        .tick(interval_tick)
    );

    // ============================================================
    // helpers
    function automatic logic ph_ok(input logic [`VRC_PH_W-1:0] v,
                                   input logic [`VRC_PH_W-1:0] cfg);
        ph_ok = (v >= `VRC_PH_MIN) && (v <= `VRC_PH_MAX) && (v <= cfg);
    endfunction

    logic wr;
    logic rd;
    logic unlocked_wr;
    logic [`VRC_PH_W-1:0] w_ph0;
    logic [`VRC_PH_W-1:0] w_ph1;
    logic [`VRC_PH_W-1:0] w_ph2;
    logic signed [11:0] trimmed;
    logic [`VRC_THREAD_W:0] target;

    assign wr = cmd.valid && cmd.write;
    assign rd = cmd.valid && !cmd.write;
    assign restart = wr && (cmd.code == `VRC_CODE_ENERGY_THREAD);
    assign unlocked_wr = wr && link_register_lock_released;
    assign w_ph0 = cmd.wdata[`VRC_PH0_LSB +: `VRC_PH_W];
    assign w_ph1 = cmd.wdata[`VRC_PH1_LSB +: `VRC_PH_W];
    assign w_ph2 = cmd.wdata[`VRC_PH2_LSB +: `VRC_PH_W];
    // signed trim widened to 12 bits so a negative offset cannot wrap
    assign trimmed = $signed({2'h0, vout_command_vid}) +
        12'($signed(st_reg.trim));
    // a zero count stands for the full 2^20 intervals
    assign target = (st_reg.thread == '0) ? THREAD_FULL :
        {1'b0, st_reg.thread};

    // ============================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.rsp.valid = 1'b0;
        st_next.rsp.unmapped = 1'b0;
        st_next.unsup = 1'b0;

        // host writes
        if (wr) begin
            case (cmd.code)
                `VRC_CODE_OUTPUT_TRIM_STEPS: begin
                    st_next.trim = cmd.wdata[`VRC_TRIM_W-1:0];
                end
                `VRC_CODE_MIN_PHASE_PER_STATE: begin
                    if (ph_ok(w_ph0, configured_phases) &&
                        ph_ok(w_ph1, configured_phases) &&
                        ph_ok(w_ph2, configured_phases)) begin
                        st_next.shed = cmd.wdata[`VRC_SHED_W-1:0];
                    end else begin
                        st_next.unsup = 1'b1;
                    end
                end
                `VRC_CODE_ENERGY_THREAD: begin
                    st_next.thread = cmd.wdata[`VRC_THREAD_W-1:0];
                    st_next.en_state = vrc_cfg_pkg::VRC_EN_RUN;
                    st_next.en_count = '0;
                    st_next.en_total = '0;
                end
                default: begin
                end
            endcase
        end

        // lock-gated mirrors; a locked write falls through untouched
        if (unlocked_wr) begin
            case (cmd.code)
                `VRC_CODE_LINK_TEMP_ZONE: st_next.view.temp_zone = cmd.wdata[7:0];
                `VRC_CODE_LINK_OUTPUT_CURRENT: st_next.view.iout = cmd.wdata[7:0];
                `VRC_CODE_LINK_LAST_VID: st_next.vid = cmd.wdata[`VRC_VID_W-1:0];
                `VRC_CODE_LINK_LAST_PSTATE: st_next.pstate = cmd.wdata[7:0];
                `VRC_CODE_LINK_OFFSET: st_next.view.offset = cmd.wdata[7:0];
                `VRC_CODE_LINK_MAX_CURRENT: st_next.view.max_current = cmd.wdata[7:0];
                `VRC_CODE_LINK_MAX_TEMP: st_next.view.max_temp = cmd.wdata[7:0];
                `VRC_CODE_LINK_FAST_SLEW: st_next.view.fast_slew = cmd.wdata[7:0];
                `VRC_CODE_LINK_SLOW_SLEW: st_next.view.slow_slew = cmd.wdata[7:0];
                default: begin
                end
            endcase
        end

        // link updates land after host writes, so a live command wins the cycle
        if (link_upd.vid_valid) begin
            st_next.vid = link_upd.vid;
        end
        if (link_upd.pstate_valid) begin
            st_next.pstate = link_upd.pstate;
        end
        if (link_upd.temp_valid) begin
            st_next.view.temp_zone = link_upd.temp;
        end
        if (link_upd.iout_valid) begin
            st_next.view.iout = link_upd.iout;
        end
        if (link_upd.offset_valid) begin
            st_next.view.offset = link_upd.offset;
        end

        // energy accumulation
        case (st_reg.en_state)
            vrc_cfg_pkg::VRC_EN_RUN: begin
                if (interval_tick && !(wr && cmd.code == `VRC_CODE_ENERGY_THREAD)) begin
                    st_next.en_total = st_reg.en_total +
                        `VRC_ENERGY_W'(interval_avg_power);
                    st_next.en_count = st_reg.en_count + 1'b1;
                    if (st_reg.en_count + 1'b1 == target) begin
                        st_next.en_state = vrc_cfg_pkg::VRC_EN_DONE;
                    end
                end
            end
            vrc_cfg_pkg::VRC_EN_IDLE: begin
            end
            vrc_cfg_pkg::VRC_EN_DONE: begin
            end
            default: begin
                st_next.en_state = vrc_cfg_pkg::VRC_EN_IDLE;
            end
        endcase

        // setpoint: trim only in the management-bus domain, clamped to the code range
        if (link_control) begin
            st_next.setpoint = st_reg.vid;
        end else if (trimmed < 12'sd0) begin
            st_next.setpoint = '0;
        end else if (trimmed > 12'sd1023) begin
            st_next.setpoint = '1;
        end else begin
            st_next.setpoint = trimmed[`VRC_VID_W-1:0];
        end

        // power-state minimum selection
        if (link_control && st_reg.pstate == 8'h01) begin
            st_next.min_phases = st_reg.shed[`VRC_PH1_LSB +: `VRC_PH_W];
        end else if (link_control && st_reg.pstate == 8'h02) begin
            st_next.min_phases = st_reg.shed[`VRC_PH2_LSB +: `VRC_PH_W];
        end else begin
            st_next.min_phases = st_reg.shed[`VRC_PH0_LSB +: `VRC_PH_W];
        end

        // reads answer one cycle later from flip-flops
        if (rd) begin
            st_next.rsp.valid = 1'b1;
            st_next.rsp.data = '0;
            case (cmd.code)
                `VRC_CODE_OUTPUT_TRIM_STEPS: st_next.rsp.data[7:0] = st_reg.trim;
                `VRC_CODE_MIN_PHASE_PER_STATE: st_next.rsp.data[12:0] = st_reg.shed;
                `VRC_CODE_LINK_TEMP_ZONE: st_next.rsp.data[7:0] = st_reg.view.temp_zone;
                `VRC_CODE_LINK_OUTPUT_CURRENT: st_next.rsp.data[7:0] = st_reg.view.iout;
                `VRC_CODE_LINK_LAST_VID: st_next.rsp.data[9:0] = st_reg.vid;
                `VRC_CODE_LINK_LAST_PSTATE: st_next.rsp.data[7:0] = st_reg.pstate;
                `VRC_CODE_LINK_OFFSET: st_next.rsp.data[7:0] = st_reg.view.offset;
                `VRC_CODE_ENERGY_THREAD: st_next.rsp.data[19:0] = st_reg.thread;
                `VRC_CODE_LINK_MAX_CURRENT: st_next.rsp.data[7:0] = st_reg.view.max_current;
                `VRC_CODE_LINK_MAX_TEMP: st_next.rsp.data[7:0] = st_reg.view.max_temp;
                `VRC_CODE_LINK_FAST_SLEW: st_next.rsp.data[7:0] = st_reg.view.fast_slew;
                `VRC_CODE_LINK_SLOW_SLEW: st_next.rsp.data[7:0] = st_reg.view.slow_slew;
                default: st_next.rsp.unmapped = 1'b1;
            endcase
        end
    end

    // ============================================================
    // state register
    // no storage image is loaded or saved: every mirror restarts at its reset value
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.trim <= `VRC_RST_TRIM;
            st_reg.shed <= `VRC_RST_SHED;
            st_reg.view <= '0;
            st_reg.vid <= `VRC_RST_VID;
            st_reg.pstate <= `VRC_RST_MIRROR;
            st_reg.thread <= `VRC_RST_THREAD;
            st_reg.min_phases <= `VRC_PH_MIN;
            st_reg.en_state <= vrc_cfg_pkg::VRC_EN_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // outputs
    // the link view carries report values only; no protection path reads them
    assign link_view = st_reg.view;
    assign rsp = st_reg.rsp;
    assign cml_unsupported_data_set = st_reg.unsup;
    assign setpoint_vid = st_reg.setpoint;
    assign min_phases_active = st_reg.min_phases;
    assign skip_offset_fraction = st_reg.shed[`VRC_FRACT_LSB +: `VRC_FRACT_W];
    assign energy_total = st_reg.en_total;
    assign energy_running = (st_reg.en_state == vrc_cfg_pkg::VRC_EN_RUN);
    assign energy_done = (st_reg.en_state == vrc_cfg_pkg::VRC_EN_DONE);
endmodule

// ==== hdl/vrc_cfg_regs.svh ====
// register codes, field positions, reset values and timing counts of the config bank
`ifndef VRC_CFG_REGS_SVH
`define VRC_CFG_REGS_SVH

// ============================================================
// command codes
`define VRC_CODE_OUTPUT_TRIM_STEPS 16'h00FA
`define VRC_CODE_MIN_PHASE_PER_STATE 16'h00FB
`define VRC_CODE_LINK_TEMP_ZONE 16'hFE02
`define VRC_CODE_LINK_OUTPUT_CURRENT 16'hFE03
`define VRC_CODE_LINK_LAST_VID 16'hFE04
`define VRC_CODE_LINK_LAST_PSTATE 16'hFE05
`define VRC_CODE_LINK_OFFSET 16'hFE06
`define VRC_CODE_ENERGY_THREAD 16'hFE07
`define VRC_CODE_LINK_MAX_CURRENT 16'hFE08
`define VRC_CODE_LINK_MAX_TEMP 16'hFE09
`define VRC_CODE_LINK_FAST_SLEW 16'hFE0A
`define VRC_CODE_LINK_SLOW_SLEW 16'hFE0B

// ============================================================
// field positions
`define VRC_TRIM_W 8
`define VRC_SHED_W 13
`define VRC_PH0_LSB 0
`define VRC_PH1_LSB 3
`define VRC_FRACT_LSB 6
`define VRC_FRACT_W 4
`define VRC_PH2_LSB 10
`define VRC_PH_W 3
`define VRC_VID_W 10
`define VRC_MIRROR_W 8
`define VRC_THREAD_W 20
`define VRC_POWER_W 16
`define VRC_ENERGY_W 40
`define VRC_PH_MIN 3'h1
`define VRC_PH_MAX 3'h6

// ============================================================
// reset values
`define VRC_RST_TRIM 8'h00
`define VRC_RST_SHED 13'h0449
`define VRC_RST_MIRROR 8'h00
`define VRC_RST_VID 10'h000
`define VRC_RST_THREAD 20'h00000

// ============================================================
// timing
`define VRC_CLK_KHZ 250000
`define VRC_INTERVAL_US 1200
`define VRC_INTERVAL_CYCLES ((`VRC_INTERVAL_US * `VRC_CLK_KHZ) / 1000)

`endif

// ==== hdl/vrc_cfg_pkg.sv ====
// types shared by the voltage-regulator configuration bank
package vrc_cfg_pkg;
`include "vrc_cfg_regs.svh"

    typedef enum logic [1:0] {
        VRC_EN_IDLE,
        VRC_EN_RUN,
        VRC_EN_DONE
    } vrc_energy_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] code;
        logic [31:0] wdata;
    } vrc_cmd_t;

    typedef struct packed {
        logic valid;
        logic unmapped;
        logic [31:0] data;
    } vrc_rsp_t;

    typedef struct packed {
        logic vid_valid;
        logic [`VRC_VID_W-1:0] vid;
        logic pstate_valid;
        logic [`VRC_MIRROR_W-1:0] pstate;
        logic temp_valid;
        logic [`VRC_MIRROR_W-1:0] temp;
        logic iout_valid;
        logic [`VRC_MIRROR_W-1:0] iout;
        logic offset_valid;
        logic [`VRC_MIRROR_W-1:0] offset;
    } vrc_link_upd_t;

    typedef struct packed {
        logic [`VRC_MIRROR_W-1:0] temp_zone;
        logic [`VRC_MIRROR_W-1:0] iout;
        logic [`VRC_MIRROR_W-1:0] offset;
        logic [`VRC_MIRROR_W-1:0] max_current;
        logic [`VRC_MIRROR_W-1:0] max_temp;
        logic [`VRC_MIRROR_W-1:0] fast_slew;
        logic [`VRC_MIRROR_W-1:0] slow_slew;
    } vrc_link_view_t;

    typedef struct packed {
        logic [`VRC_TRIM_W-1:0] trim;
        logic [`VRC_SHED_W-1:0] shed;
        vrc_link_view_t view;
        logic [`VRC_VID_W-1:0] vid;
        logic [`VRC_MIRROR_W-1:0] pstate;
        logic [`VRC_THREAD_W-1:0] thread;
        vrc_energy_state_t en_state;
        logic [`VRC_THREAD_W:0] en_count;
        logic [`VRC_ENERGY_W-1:0] en_total;
        logic [`VRC_VID_W-1:0] setpoint;
        logic [`VRC_PH_W-1:0] min_phases;
        vrc_rsp_t rsp;
        logic unsup;
    } vrc_state_t;
endpackage

// ==== hdl/vrc_interval_tick.sv ====
// free interval divider: one-cycle tick every PERIOD cycles while run is high
`timescale 1ns/1ps
module vrc_interval_tick #(
    parameter int CNT_W = 20,
    parameter logic [CNT_W-1:0] PERIOD = 20'h493E0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } vrc_tick_state_t;

    vrc_tick_state_t st_reg;
    vrc_tick_state_t st_next;

    // ============================================================
    // counter
    // restarting from zero on every start keeps the first interval full length
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!run) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt == PERIOD - 1'b1) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule

// ==== bench/vrc_cfg_bank_props.sv ====
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`include "vrc_cfg_regs.svh"
module vrc_cfg_bank_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input vrc_cfg_pkg::vrc_cmd_t cmd,
    input vrc_cfg_pkg::vrc_rsp_t rsp,
    input wire logic cml_unsupported_data_set,
    input wire logic [`VRC_PH_W-1:0] configured_phases,
    input wire logic link_control,
    input wire logic link_register_lock_released,
    input vrc_cfg_pkg::vrc_link_upd_t link_upd,
    input vrc_cfg_pkg::vrc_link_view_t link_view,
    input wire logic [`VRC_VID_W-1:0] setpoint_vid,
    input wire logic [`VRC_PH_W-1:0] min_phases_active,
    input wire logic energy_running,
    input wire logic energy_done
);
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ============================================================
    // sequences
    sequence shed_over;
        cmd.valid && cmd.write && cmd.code == 16'h00FB && cmd.wdata[2:0] > configured_phases;
    endsequence
    // a second vid update in the gap would move the setpoint target
    sequence vid_quiet;
        link_upd.vid_valid && link_control ##1 link_control && !link_upd.vid_valid;
    endsequence
    // ============================================================
    // properties
    read_answer_a: assert property (cmd.valid && !cmd.write |=> rsp.valid)
        else $error("read got no answer");
    answer_cause_a: assert property (rsp.valid |-> $past(cmd.valid && !cmd.write))
        else $error("answer without read");
    shed_reject_a: assert property (shed_over |=> cml_unsupported_data_set)
        else $error("oversize phase minimum not flagged");
    reject_cause_a: assert property (cml_unsupported_data_set |->
        $past(cmd.valid && cmd.write && cmd.code == 16'h00FB))
        else $error("flag without phase write");
    link_setpoint_a: assert property (vid_quiet |=> setpoint_vid == $past(link_upd.vid, 2))
        else $error("link setpoint not followed");
    phase_range_a: assert property (min_phases_active >= 3'h1 && min_phases_active <= 3'h6)
        else $error("phase minimum out of range");
    temp_mirror_a: assert property (link_upd.temp_valid |=>
        link_view.temp_zone == $past(link_upd.temp))
        else $error("temperature mirror not updated");
    lock_hold_a: assert property (cmd.valid && cmd.write && cmd.code == 16'hFE09 &&
        !link_register_lock_released |=> $stable(link_view.max_temp))
        else $error("locked mirror changed");
    energy_start_a: assert property (cmd.valid && cmd.write && cmd.code == 16'hFE07 |=>
        energy_running && !energy_done)
        else $error("energy run not started");
    energy_end_a: assert property ($fell(energy_running) |-> energy_done)
        else $error("energy run stopped without done");
endmodule
bind vrc_cfg_bank vrc_cfg_bank_props u_props (.clk_sys(clk_sys), .resetn(resetn), .cmd(cmd),
    .rsp(rsp), .cml_unsupported_data_set(cml_unsupported_data_set),
    .configured_phases(configured_phases), .link_control(link_control),
    .link_register_lock_released(link_register_lock_released), .link_upd(link_upd),
    .link_view(link_view), .setpoint_vid(setpoint_vid), .min_phases_active(min_phases_active),
    .energy_running(energy_running), .energy_done(energy_done));

// ==== bench/vrc_link_model.sv ====
// processor voltage link model: one mirror update strobe per request
`timescale 1ns/1ps
module vrc_link_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [9:0] val,
    output vrc_cfg_pkg::vrc_link_upd_t link_upd
);
    logic [9:0] last_reg = 10'h000;
    logic [4:0] hit_reg = 5'h00;
    always_ff @(posedge clk_sys) begin
        hit_reg <= go ? (5'h01 << kind) : 5'h00;
        if (go) begin
            last_reg <= val;
        end
    end
    // between strobes the values flip so a stale sample cannot pass
    always_comb begin
        logic [9:0] v;
        v = (hit_reg != 5'h00) ? last_reg : ~last_reg;
        link_upd = '{hit_reg[0], v, hit_reg[1], v[7:0], hit_reg[2], v[7:0],
            hit_reg[3], v[7:0], hit_reg[4], v[7:0]};
    end
endmodule

// ==== bench/tb_vrc_cfg_bank.sv ====
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_vrc_cfg_bank;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    vrc_cfg_pkg::vrc_cmd_t cmd = '0;
    vrc_cfg_pkg::vrc_rsp_t rsp;
    vrc_cfg_pkg::vrc_link_upd_t link_upd;
    vrc_cfg_pkg::vrc_link_view_t link_view;
    logic cml_unsupported_data_set, energy_running, energy_done, lk_go = 1'b0;
    logic [2:0] configured_phases = 3'h6;
    logic [2:0] lk_kind = 3'h0;
    logic [2:0] min_phases_active;
    logic link_control = 1'b0;
    logic link_register_lock_released = 1'b0;
    logic [9:0] vout_command_vid = 10'h100;
    logic [9:0] lk_val = 10'h000;
    logic [9:0] setpoint_vid;
    logic [3:0] skip_offset_fraction;
    logic [15:0] interval_avg_power = 16'h0100;
    logic [39:0] energy_total;
    int num_errors = 0;
    int total_checks = 0;
    logic [15:0] codes [9] = '{16'hFE02, 16'hFE03, 16'hFE04, 16'hFE05, 16'hFE06, 16'hFE08,
        16'hFE09, 16'hFE0A, 16'hFE0B};
    vrc_cfg_bank #(.INTERVAL_CYCLES(10)) DUT (.clk_sys(clk_sys), .resetn(resetn), .cmd(cmd),
        .rsp(rsp), .cml_unsupported_data_set(cml_unsupported_data_set),
        .configured_phases(configured_phases), .link_control(link_control),
        .link_register_lock_released(link_register_lock_released),
        .vout_command_vid(vout_command_vid), .link_upd(link_upd), .link_view(link_view),
        .setpoint_vid(setpoint_vid), .min_phases_active(min_phases_active),
        .skip_offset_fraction(skip_offset_fraction), .interval_avg_power(interval_avg_power),
        .energy_total(energy_total), .energy_running(energy_running), .energy_done(energy_done));
    vrc_link_model u_link (.clk_sys(clk_sys), .go(lk_go), .kind(lk_kind), .val(lk_val),
        .link_upd(link_upd));
    // ============================================================
    // bus and helper tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic bus(input logic w, input logic [15:0] c, input logic [31:0] d);
        @(posedge clk_sys);
        cmd <= '{1'b1, w, c, d};
        @(posedge clk_sys);
        cmd <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] c, input logic [31:0] e, input string n);
        bus(1'b0, c, 32'h0);
        `CHK(n, e, rsp.data)
    endtask
    task automatic lk(input logic [2:0] k, input logic [9:0] v);
        @(posedge clk_sys);
        lk_go <= 1'b1;
        lk_kind <= k;
        lk_val <= v;
        @(posedge clk_sys);
        lk_go <= 1'b0;
        step(4);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 100 && energy_done !== 1'b1; i++) begin
            step(1);
        end
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        rd(16'h00FA, 32'h0, "trim");
        rd(16'h00FB, 32'h449, "shed");
        foreach (codes[i]) rd(codes[i], 32'h0, "mirror");
        `CHK("minph", 3'h1, min_phases_active)
        `CHK("fract", 4'h1, skip_offset_fraction)
    endtask
    task automatic t_lock();
        foreach (codes[i]) bus(1'b1, codes[i], 32'h35A);
        foreach (codes[i]) rd(codes[i], 32'h0, "locked");
        @(posedge clk_sys);
        link_register_lock_released <= 1'b1;
        foreach (codes[i]) bus(1'b1, codes[i], 32'h35A);
        foreach (codes[i]) rd(codes[i], codes[i] == 16'hFE04 ? 32'h35A : 32'h5A, "open");
        `CHK("view", {7{8'h5A}}, link_view)
        lk(3'h2, 10'h0C3);
        `CHK("tzone", 8'hC3, link_view.temp_zone)
        lk(3'h3, 10'h0A7);
        `CHK("iout", 8'hA7, link_view.iout)
        lk(3'h4, 10'h01E);
        `CHK("offs", 8'h1E, link_view.offset)
        rd(16'h1234, 32'h0, "unmapped");
        `CHK("unm", 1'b1, rsp.unmapped)
    endtask
    task automatic t_trim();
        bus(1'b1, 16'h00FA, 32'h05);
        step(2);
        `CHK("trim_pos", 10'h105, setpoint_vid)
        bus(1'b1, 16'h00FA, 32'hFE);
        bus(1'b1, 16'hFE06, 32'hFE);
        `CHK("trim_neg", 10'h0FE, setpoint_vid)
        @(posedge clk_sys);
        vout_command_vid <= 10'h001;
        step(3);
        `CHK("clamp", 10'h000, setpoint_vid)
        @(posedge clk_sys);
        link_control <= 1'b1;
        lk(3'h0, 10'h2A0);
        `CHK("link_sp", 10'h2A0, setpoint_vid)
        rd(16'hFE04, 32'h2A0, "vid");
    endtask
    task automatic t_shed();
        @(posedge clk_sys);
        configured_phases <= 3'h4;
        link_control <= 1'b0;
        bus(1'b1, 16'h00FB, 32'hD54);
        rd(16'h00FB, 32'hD54, "shed");
        `CHK("ph0", 3'h4, min_phases_active)
        `CHK("fr", 4'h5, skip_offset_fraction)
        bus(1'b1, 16'h00FB, 32'hD55);
        `CHK("unsup", 1'b1, cml_unsupported_data_set)
        rd(16'h00FB, 32'hD54, "kept");
        lk(3'h1, 10'h001);
        `CHK("ps1_pm", 3'h4, min_phases_active)
        @(posedge clk_sys);
        link_control <= 1'b1;
        step(3);
        `CHK("ps1", 3'h2, min_phases_active)
        lk(3'h1, 10'h002);
        `CHK("ps2", 3'h3, min_phases_active)
        rd(16'hFE05, 32'h2, "pstate");
        lk(3'h1, 10'h000);
        `CHK("ps0", 3'h4, min_phases_active)
    endtask
    task automatic t_energy();
        bus(1'b1, 16'hFE07, 32'h3);
        wait_done();
        `CHK("total3", 40'h300, energy_total)
        `CHK("stop", 1'b0, energy_running)
        `CHK("done", 1'b1, energy_done)
        bus(1'b1, 16'hFE07, 32'h5);
        step(15);
        @(posedge clk_sys);
        interval_avg_power <= 16'h0023;
        bus(1'b1, 16'hFE07, 32'h1);
        step(8);
        `CHK("early", 1'b0, energy_done)
        wait_done();
        `CHK("restart", 40'h23, energy_total)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ============================================================
    // clock, sequence and watchdog
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        step(1);
        t_reset();
        t_lock();
        t_trim();
        t_shed();
        t_energy();
        wrap_up();
    end
    // the scenarios need well under a thousand cycles
    initial begin
        #20000;
        num_errors++;
        wrap_up();
    end
endmodule
